// >>> sarc_consts.vh
// Constants for the successive-approximation converter control block.
`ifndef SARC_CONSTS_VH
`define SARC_CONSTS_VH
`define SARC_ADDR_RESULT_LO  16'hff08
`define SARC_ADDR_RESULT_HI  16'hff09
`define SARC_ADDR_MODE       16'hff28
`define SARC_ADDR_CHANNEL    16'hff29
`define SARC_MODE_RESET      8'h00
`define SARC_CHAN_RESET      8'h00
`define SARC_RESULT_RESET    10'h000
`define SARC_MODE_RUN        7
`define SARC_MODE_CMP        0
`define SARC_MODE_RATE_HI    5
`define SARC_MODE_RATE_LO    1
`define SARC_MODE_RSVD       6
`define SARC_RATE_264        5'h01
`define SARC_RATE_176        5'h05
`define SARC_RATE_132        5'h09
`define SARC_RATE_88         5'h0d
`define SARC_RATE_66         5'h11
`define SARC_RATE_44         5'h15
`define SARC_DIV_264         4'hc
`define SARC_DIV_176         4'h8
`define SARC_DIV_132         4'h6
`define SARC_DIV_88          4'h4
`define SARC_DIV_66          4'h3
`define SARC_DIV_44          4'h2
`define SARC_SAMPLE_STEPS    5'h0c
`define SARC_RES_BITS        10
`define SARC_LOW_ZERO_BITS   6'h00
`define SARC_CHAN_BITS       2
`define SARC_BIT_COUNT_TOP   4'h9
`endif

// >>> sarc_divider.v
// Conversion clock divider producing one step pulse per divided period.
`timescale 1ns/1ps
`default_nettype none
module sarc_divider #(
   parameter W = 4
) (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire         run,
   input  wire [W-1:0] div,
   output wire         step
);
   reg [W-1:0] cnt_q;
   reg [W-1:0] cnt_d;

   assign step = run && (div != {W{1'b0}}) && (cnt_q == div - 1'b1);

   always @* begin
      cnt_d = cnt_q;
      if (!run || step) begin
         cnt_d = {W{1'b0}};
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= {W{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // sarc_divider
`default_nettype wire

// >>> sarc_top.v
// Control, sequencing and result registers of the four-channel converter.
//
// Functional notes
// - Mode bit 7 runs or halts conversion.
// - Mode bit 0 powers the comparator.
// - Both bits clear: fully stopped, no power.
// - Comparator only: standby, no conversion.
// - Rate field selects divider and time.
// - Result reads and mode/channel writes insert one bus wait.
// - Word result left aligned, low zeros.
// - High byte at higher address.
// - Word result read only as 16 bits.
// - High byte register holds top eight bits.
// - Channel field selects input zero to three.
// - Single-bit and byte writes both accepted.
// - Reset clears all four registers.
// - Ten-bit MSB-first approximation, then done pulse.
// - Conversions repeat while run bit set.
// - Channel write aborts and restarts conversion.
`timescale 1ns/1ps
`default_nettype none
`include "sarc_consts.vh"
module sarc_top #(
   parameter ADDR_W = 16
) (
   input  wire              mclk,
   input  wire              rst_n,
   input  wire [ADDR_W-1:0] bus_addr,
   input  wire              bus_wr,
   input  wire              bus_rd,
   input  wire              bus_word,
   input  wire              bus_bit,
   input  wire [2:0]        bus_bit_sel,
   input  wire [7:0]        bus_wdata,
   output reg  [15:0]       bus_rdata,
   output wire              bus_wait,
   input  wire              cmp_decision,
   output reg  [9:0]        trial_level,
   output reg  [1:0]        analog_select,
   output wire              sample_hold,
   output wire              comparator_power,
   output wire              string_power,
   output reg               conversion_done_irq
);
   localparam ST_IDLE   = 3'b001;
   localparam ST_SAMPLE = 3'b010;
   localparam ST_CONV   = 3'b100;

   reg [7:0]  mode_q;
   reg [7:0]  chan_q;
   reg [9:0]  result_q;
   reg [9:0]  sar_q;
   reg [3:0]  bit_q;
   reg [4:0]  smp_q;
   reg [2:0]  st_q;
   reg        wait_q;
   reg [7:0]  mode_d;
   reg [7:0]  chan_d;
   reg [2:0]  st_d;
   reg [9:0]  sar_d;
   reg [3:0]  bit_d;
   reg [4:0]  smp_d;
   reg [9:0]  result_d;
   reg        done_d;
   reg [3:0]  div_sel;

   wire run_bit  = mode_q[`SARC_MODE_RUN];
   wire cmp_bit  = mode_q[`SARC_MODE_CMP];
   wire [4:0] rate = mode_q[`SARC_MODE_RATE_HI:`SARC_MODE_RATE_LO];
   wire hit_lo   = (bus_addr == `SARC_ADDR_RESULT_LO);
   wire hit_hi   = (bus_addr == `SARC_ADDR_RESULT_HI);
   wire hit_mode = (bus_addr == `SARC_ADDR_MODE);
   wire hit_chan = (bus_addr == `SARC_ADDR_CHANNEL);
   wire wr_mode  = bus_wr && hit_mode && !wait_q;
   wire wr_chan  = bus_wr && hit_chan && !wait_q;
   wire access   = (bus_wr && (hit_mode || hit_chan)) ||
                   (bus_rd && (hit_lo || hit_hi));
   wire step;
   wire legal = (div_sel != 4'h0);

   // Merges a byte write or a single-bit write into a register.
   function [7:0] merge;
      input [7:0] old;
      input       one_bit;
      input [2:0] sel;
      input [7:0] wd;
      begin
         merge = wd;
         if (one_bit) begin
            merge = old;
            merge[sel] = wd[0];
         end
      end
   endfunction

   // Each result read and each mode or channel write stretches by one wait cycle before it completes.
   assign bus_wait = access && !wait_q;

   assign sample_hold      = (st_q == ST_SAMPLE);
   // Comparator stays off unless the enable bit or a conversion needs it.
   assign comparator_power = cmp_bit || run_bit;
   assign string_power     = run_bit;

   always @* begin
      case (rate)
         `SARC_RATE_264: div_sel = `SARC_DIV_264;
         `SARC_RATE_176: div_sel = `SARC_DIV_176;
         `SARC_RATE_132: div_sel = `SARC_DIV_132;
         `SARC_RATE_88:  div_sel = `SARC_DIV_88;
         `SARC_RATE_66:  div_sel = `SARC_DIV_66;
         `SARC_RATE_44:  div_sel = `SARC_DIV_44;
         default:        div_sel = 4'h0;
      endcase
   end

   sarc_divider #(
      .W (4)
   ) u_div (
      .mclk  (mclk),
      .rst_n (rst_n),
      .run   (run_bit && legal && (st_q != ST_IDLE)),
      .div   (div_sel),
      .step  (step)
   );

   always @* begin
      mode_d = mode_q;
      chan_d = chan_q;
      if (wr_mode) begin
         mode_d = merge(mode_q, bus_bit, bus_bit_sel, bus_wdata);
         mode_d[`SARC_MODE_RSVD] = 1'b0;
      end
      if (wr_chan) begin
         chan_d = merge(chan_q, bus_bit, bus_bit_sel, bus_wdata);
         chan_d[7:`SARC_CHAN_BITS] = 6'h00;
      end
   end

   always @* begin
      st_d     = st_q;
      sar_d    = sar_q;
      bit_d    = bit_q;
      smp_d    = smp_q;
      result_d = result_q;
      done_d   = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (run_bit && legal) begin
               st_d  = ST_SAMPLE;
               smp_d = 5'h00;
            end
         end
         ST_SAMPLE: begin
            if (step) begin
               smp_d = smp_q + 1'b1;
               if (smp_q == `SARC_SAMPLE_STEPS - 1'b1) begin
                  st_d  = ST_CONV;
                  bit_d = `SARC_BIT_COUNT_TOP;
                  sar_d = 10'h200;
               end
            end
         end
         ST_CONV: begin
            if (step) begin
               sar_d[bit_q] = cmp_decision;
               if (bit_q == 4'h0) begin
                  result_d = {sar_q[9:1], cmp_decision};
                  done_d   = 1'b1;
                  st_d     = ST_SAMPLE;
                  smp_d    = 5'h00;
               end else begin
                  sar_d[bit_q - 1'b1] = 1'b1;
                  bit_d = bit_q - 1'b1;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (!run_bit || !legal || wr_chan) begin
         st_d   = ST_IDLE;
         done_d = 1'b0;
      end
   end

   always @* begin
      bus_rdata = 16'h0000;
      if (bus_rd && hit_lo && bus_word) begin
         bus_rdata = {result_q, `SARC_LOW_ZERO_BITS};
      end else if (bus_rd && hit_hi && !bus_word) begin
         bus_rdata = {8'h00, result_q[9:2]};
      end else if (bus_rd && hit_mode) begin
         bus_rdata = {8'h00, mode_q};
      end else if (bus_rd && hit_chan) begin
         bus_rdata = {8'h00, chan_q};
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q              <= `SARC_MODE_RESET;
         chan_q              <= `SARC_CHAN_RESET;
         result_q            <= `SARC_RESULT_RESET;
         sar_q               <= 10'h000;
         bit_q               <= 4'h0;
         smp_q               <= 5'h00;
         st_q                <= ST_IDLE;
         wait_q              <= 1'b0;
         trial_level         <= 10'h000;
         analog_select       <= 2'h0;
         conversion_done_irq <= 1'b0;
      end else begin
         mode_q              <= mode_d;
         chan_q              <= chan_d;
         result_q            <= result_d;
         sar_q               <= sar_d;
         bit_q               <= bit_d;
         smp_q               <= smp_d;
         st_q                <= st_d;
         wait_q              <= bus_wait;
         trial_level         <= sar_d;
         analog_select       <= chan_d[`SARC_CHAN_BITS-1:0];
         conversion_done_irq <= done_d;
      end
   end
endmodule // sarc_top
`default_nettype wire

// >>> sarc_monitor.sv
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module sarc_monitor (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [15:0] bus_addr,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic        bus_word,
   input wire logic        bus_bit,
   input wire logic [7:0]  bus_wdata,
   input wire logic [15:0] bus_rdata,
   input wire logic        bus_wait,
   input wire logic [1:0]  analog_select,
   input wire logic        sample_hold,
   input wire logic        comparator_power,
   input wire logic        string_power,
   input wire logic        conversion_done_irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire tw = bus_wr && !bus_wait && !bus_bit;
   wire rw = bus_rd && bus_word;
   wire rb = bus_rd && !bus_word;
   wait_first_a: assert property ($rose(bus_wr) &&
      bus_addr[15:1] == 15'h7f94 |-> bus_wait) else $error("wait missing");
   wait_once_a: assert property (bus_wait |=> !bus_wait)
      else $error("wait too long");
   mode_load_a: assert property (tw && bus_addr == 16'hff28 |=>
      string_power == $past(bus_wdata[7]) &&
      comparator_power == ($past(bus_wdata[7]) | $past(bus_wdata[0])))
      else $error("mode power wrong");
   idle_quiet_a: assert property (!string_power &&
      !$past(string_power) |-> !conversion_done_irq && !sample_hold)
      else $error("activity while halted");
   word_low_a: assert property (rw && bus_addr == 16'hff08 |->
      bus_rdata[5:0] == 6'h00) else $error("word low bits set");
   word_only_a: assert property (rb && bus_addr == 16'hff08 |->
      bus_rdata == 16'h0000) else $error("byte read of word");
   byte_high_a: assert property (rb && bus_addr == 16'hff09 |->
      bus_rdata[15:8] == 8'h00) else $error("high byte wide");
   chan_load_a: assert property (tw && bus_addr == 16'hff29 |=>
      analog_select == $past(bus_wdata[1:0])) else $error("channel wrong");
   done_pulse_a: assert property (conversion_done_irq |=>
      !conversion_done_irq) else $error("done pulse long");
   cover property (conversion_done_irq);
   cover property (tw && bus_addr == 16'hff29 && string_power);
   cover property (bus_bit && bus_wr && !bus_wait);
endmodule // sarc_monitor
bind sarc_top sarc_monitor u_mon (.mclk(mclk), .rst_n(rst_n),
   .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_word(bus_word), .bus_bit(bus_bit), .bus_wdata(bus_wdata),
   .bus_rdata(bus_rdata),
   .bus_wait(bus_wait), .analog_select(analog_select),
   .sample_hold(sample_hold), .comparator_power(comparator_power),
   .string_power(string_power), .conversion_done_irq(conversion_done_irq));
`default_nettype wire

// >>> sarc_tb.sv
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk, rst_n, wr, rd, wd, bb, cmp;
   logic [15:0] a, q;
   logic [2:0]  bs;
   logic [7:0]  d;
   logic [9:0]  ain [4];
   wire  [15:0] rq;
   wire  [9:0]  tl;
   wire  [1:0]  ch;
   wire         w, dn, sp, cp;
   int          num_errors, n_checks, n;
   sarc_top DUT (.mclk(mclk), .rst_n(rst_n), .bus_addr(a), .bus_wr(wr),
      .bus_rd(rd), .bus_word(wd), .bus_bit(bb), .bus_bit_sel(bs),
      .bus_wdata(d), .bus_rdata(rq), .bus_wait(w), .cmp_decision(cmp),
      .trial_level(tl), .analog_select(ch), .sample_hold(),
      .comparator_power(cp), .string_power(sp), .conversion_done_irq(dn));
   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) cmp <= #1 (ain[ch] >= tl);
   task automatic chk(input string nm, input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Bit writes take the bit number from dat[7:5] and the value from dat[0].
   task automatic acc(input logic [15:0] ad, input logic r, b, w16,
                      input logic [7:0] dat, output logic [15:0] v);
      @(posedge mclk);
      #1 {a, rd, wr, bb, wd, d, bs} = {ad, r, !r, b, w16, dat, dat[7:5]};
      n = 0;
      @(negedge mclk);
      while (w === 1'b1 && n < 4) begin
         n++;
         @(negedge mclk);
      end
      v = rq;
      @(posedge mclk);
      #1 {rd, wr} = 2'b00;
   endtask
   task automatic wdone(output int c);
      c = 0;
      do begin
         @(negedge mclk);
         c++;
      end while (dn !== 1'b1 && c < 2000);
      chk("done seen", {15'h0000, dn}, 1);
   endtask
   task automatic t_reset;
      acc(16'hff08, 1, 0, 1, 0, q); chk("word", q, 0);
      chk("word wait", 16'(n), 1);
      acc(16'hff08, 1, 0, 0, 0, q); chk("word as byte", q, 0);
      acc(16'hff09, 1, 0, 0, 0, q); chk("high", q, 0);
      acc(16'hff28, 1, 0, 0, 0, q); chk("mode", q, 0);
      acc(16'hff29, 1, 0, 0, 0, q); chk("chan", q, 0);
      $display("t_reset done");
   endtask
   task automatic t_bits;
      acc(16'hff28, 0, 1, 0, 8'h01, q);
      chk("mode wait", 16'(n), 1);
      acc(16'hff28, 0, 1, 0, 8'hc1, q);
      acc(16'hff28, 1, 0, 0, 0, q); chk("mode bit", q, 1);
      chk("standby", {cp, sp}, 2);
      acc(16'hff29, 0, 0, 0, 8'hff, q);
      acc(16'hff29, 1, 0, 0, 0, q); chk("chan mask", q, 3);
      acc(16'hff28, 0, 1, 0, 8'h00, q); chk("stop", {cp, sp}, 0);
      acc(16'h1234, 1, 0, 1, 0, q); chk("unmapped", q, 0);
      $display("t_bits done");
   endtask
   task automatic t_rates;
      int c, k;
      logic [4:0] code [6] = '{5'h01, 5'h05, 5'h09, 5'h0d, 5'h11, 5'h15};
      int per [6] = '{264, 176, 132, 88, 66, 44};
      for (k = 0; k < 6; k++) begin
         acc(16'hff29, 0, 0, 0, 8'(k % 4), q);
         acc(16'hff28, 0, 0, 0, {2'b10, code[k], 1'b1}, q);
         // The first count does not start at a done pulse, so it is dropped.
         wdone(c);
         wdone(c); chk("period", 16'(c), 16'(per[k]));
         acc(16'hff08, 1, 0, 1, 0, q);
         chk("word", q, {ain[k % 4], 6'h00});
         acc(16'hff09, 1, 0, 0, 0, q);
         chk("high", q, {8'h00, ain[k % 4][9:2]});
         acc(16'hff28, 0, 0, 0, 0, q);
      end
      $display("t_rates done");
   endtask
   task automatic t_abort;
      int c;
      acc(16'hff28, 0, 0, 0, 8'hab, q);
      wdone(c);
      repeat (20) @(posedge mclk);
      acc(16'hff29, 0, 0, 0, 8'h02, q);
      wdone(c); chk("restart", 16'(c > 40), 1);
      acc(16'hff28, 0, 0, 0, 0, q);
      $display("t_abort done");
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      {rst_n, wr, rd, bb, wd, a, d, bs} = 0;
      ain = '{10'h2a5, 10'h3ff, 10'h000, 10'h155};
      repeat (10) @(posedge mclk);
      #1 rst_n = 1;
      t_reset;
      t_bits;
      t_rates;
      t_abort;
      give_verdict;
   end
   initial begin
      #200000;
      num_errors++;
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
